// ---- shared/smw_regs.vh ----
// Constants shared by the static memory wait-state controller files.
`ifndef SMW_REGS_VH
`define SMW_REGS_VH

// Number of chip selects and width of a chip select index.
`define SMW_NUM_CS        6
`define SMW_CS_W          3
// Width of a phase counter (setup, pulse and hold in controller clocks).
`define SMW_PH_W          10
// Width of the per chip select data float cycle count.
`define SMW_FLOAT_W       4
// External wait select encodings.
`define SMW_EXTW_OFF      2'h0
`define SMW_EXTW_FROZEN   2'h2
`define SMW_EXTW_READY    2'h3
// Bit positions in the wait state indication output.
`define SMW_WS_CS         0
`define SMW_WS_RELOAD     1
`define SMW_WS_R2W        2
`define SMW_WS_FLOAT      3
// Reset values of the latched configuration.
`define SMW_RST_FLOAT     24'h000000
`define SMW_RST_OPT       6'h00
`define SMW_RST_RDCTL     6'h00
`define SMW_RST_EXTW      12'h000

`endif

// ---- src/smw_sync2.v ----
// Two flip-flop synchroniser for the external wait pin.
`timescale 1ns/1ns
module smw_sync2 (
  input  wire core_clk_i,
  input  wire rst_i,
  input  wire async_i,
  output wire sync_o
);

  reg meta_reg;
  reg sync_reg;

  // The first stage is read only by the second; the pin idles high (no wait).
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule // smw_sync2

// ---- src/smw_float_timer.v ----
// Data float period timer: counts the cycles the last read device still drives the bus.
`timescale 1ns/1ns
`include "smw_regs.vh"
module smw_float_timer (
  input  wire                    core_clk_i,
  input  wire                    rst_i,
  input  wire                    start_i,
  input  wire [`SMW_FLOAT_W-1:0] count_i,
  input  wire [`SMW_CS_W-1:0]    cs_i,
  output wire                    busy_o,
  output wire [`SMW_CS_W-1:0]    cs_o
);

  reg [`SMW_FLOAT_W-1:0] cnt_reg;
  reg [`SMW_CS_W-1:0]    cs_reg;

  // The timer runs freely, so every wait or setup cycle spent meanwhile counts toward it.
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_reg <= {`SMW_FLOAT_W{1'b0}};
      cs_reg  <= {`SMW_CS_W{1'b0}};
    end else if (start_i) begin
      cnt_reg <= count_i;
      cs_reg  <= cs_i;
    end else if (cnt_reg != {`SMW_FLOAT_W{1'b0}}) begin
      cnt_reg <= cnt_reg - {{(`SMW_FLOAT_W-1){1'b0}}, 1'b1};
    end
  end

  assign busy_o = (cnt_reg != {`SMW_FLOAT_W{1'b0}});
  assign cs_o   = cs_reg;

endmodule // smw_float_timer

// ---- src/smw_ctrl.v ----
// Wait-state sequencer of the static memory controller: automatic waits and external wait.
//
// Contract
// - A mode configuration write schedules one reload wait state before the next access.
// - Entering or leaving slow clock mode also schedules a reload wait state.
// - One read-to-write wait cycle always separates a read from a following write.
// - The read-to-write cycle follows chip select or reload waits, never merged.
// - After a read, float waits guard reads elsewhere and any write.
// - Each chip select holds a four-bit float cycle count, zero to fifteen.
// - Float waits never delay internal memory accesses.
// - With read strobe control, float starts at the read strobe rising edge.
// - With chip select control, float starts at the chip select rising edge.
// - With float optimisation, next setup cycles count toward the float period.
// - Without optimisation, float waits complete before the next access begins.
// - Without optimisation, read hold cycles overlapping float count toward it.
// - External wait select two means frozen mode, three means ready mode.
// - External wait select zero ignores the wait input on that chip select.
// - The wait input is looked at only in the strobe pulse phase.
// - Frozen mode: low wait freezes counters and outputs, then resumes exactly.
// - Ready mode: low wait in last pulse cycle suspends until release, then hold.
// - Ready mode: wait released before pulse end or raised after never lengthens.
// - One idle cycle between chip selects; a reload wait is absorbed into it.
`timescale 1ns/1ns
`include "smw_regs.vh"
module smw_ctrl (
  input  wire                        core_clk_i,
  input  wire                        rst_i,
  input  wire                        req_valid_i,
  output wire                        req_ready_o,
  input  wire                        req_write_i,
  input  wire [`SMW_CS_W-1:0]        req_cs_i,
  input  wire [`SMW_PH_W-1:0]        req_setup_i,
  input  wire [`SMW_PH_W-1:0]        req_pulse_i,
  input  wire [`SMW_PH_W-1:0]        req_hold_i,
  output wire                        done_o,
  input  wire                        int_req_i,
  output wire                        int_ack_o,
  input  wire                        mode_write_i,
  input  wire                        slow_mode_i,
  input  wire [4*`SMW_NUM_CS-1:0]    cfg_float_cycles_i,
  input  wire [`SMW_NUM_CS-1:0]      cfg_float_opt_i,
  input  wire [`SMW_NUM_CS-1:0]      cfg_read_ctrl_i,
  input  wire [2*`SMW_NUM_CS-1:0]    cfg_ext_wait_sel_i,
  input  wire                        ext_wait_n_i,
  output wire [`SMW_NUM_CS-1:0]      chip_select_n_o,
  output wire                        read_strobe_n_o,
  output wire                        write_strobe_n_o,
  output wire [3:0]                  wait_state_o,
  output wire                        float_busy_o,
  output wire                        frozen_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // States.
  localparam [3:0] ST_IDLE   = 4'h0;
  localparam [3:0] ST_CSWAIT = 4'h1;
  localparam [3:0] ST_RELOAD = 4'h2;
  localparam [3:0] ST_R2W    = 4'h3;
  localparam [3:0] ST_FLOAT  = 4'h4;
  localparam [3:0] ST_SETUP  = 4'h5;
  localparam [3:0] ST_PULSE  = 4'h6;
  localparam [3:0] ST_SUSP   = 4'h7;
  localparam [3:0] ST_HOLD   = 4'h8;
  localparam [`SMW_PH_W-1:0] PH_ONE = 10'h001;

  reg  [3:0]                 state_reg;
  reg  [3:0]                 state_next;
  reg  [`SMW_PH_W-1:0]       cnt_reg;
  reg  [`SMW_PH_W-1:0]       cnt_next;
  reg                        act_write_reg;
  reg  [`SMW_CS_W-1:0]       act_cs_reg;
  reg  [`SMW_PH_W-1:0]       act_setup_reg;
  reg  [`SMW_PH_W-1:0]       act_pulse_reg;
  reg  [`SMW_PH_W-1:0]       act_hold_reg;
  reg                        r2w_due_reg;
  reg                        after_setup_reg;
  reg                        after_setup_next;
  reg                        last_valid_reg;
  reg                        last_write_reg;
  reg  [`SMW_CS_W-1:0]       last_cs_reg;
  reg                        reload_pend_reg;
  reg                        slow_prev_reg;
  reg  [4*`SMW_NUM_CS-1:0]   lat_float_reg;
  reg  [`SMW_NUM_CS-1:0]     lat_opt_reg;
  reg  [`SMW_NUM_CS-1:0]     lat_rdctl_reg;
  reg  [2*`SMW_NUM_CS-1:0]   lat_extw_reg;
  reg  [`SMW_NUM_CS-1:0]     cs_n_reg;
  reg                        rd_n_reg;
  reg                        wr_n_reg;
  reg  [3:0]                 ws_reg;
  reg                        done_reg;
  reg                        frozen_reg;
  reg                        float_start;
  reg                        finish;

  wire                       wait_s;
  wire                       fl_busy;
  wire [`SMW_CS_W-1:0]       fl_cs;
  wire                       idle;
  wire                       sel_write;
  wire [`SMW_CS_W-1:0]       sel_cs;
  wire                       sel_opt;
  wire                       fl_block;
  wire [1:0]                 act_extw;
  wire                       act_rdctl;
  wire [`SMW_FLOAT_W-1:0]    act_float;
  wire                       need_cs;
  wire                       need_r2w;
  wire                       accept;
  wire                       slow_edge;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and float timer.
  smw_sync2 u_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .async_i    (ext_wait_n_i),
    .sync_o     (wait_s)
  );

  smw_float_timer u_float (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .start_i    (float_start),
    .count_i    (act_float),
    .cs_i       (act_cs_reg),
    .busy_o     (fl_busy),
    .cs_o       (fl_cs)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Decode of the current access and its latched chip select settings.
  assign idle      = (state_reg == ST_IDLE);
  assign accept    = idle && req_valid_i && (req_cs_i < `SMW_NUM_CS);
  assign sel_write = idle ? req_write_i : act_write_reg;
  assign sel_cs    = idle ? req_cs_i : act_cs_reg;
  assign sel_opt   = lat_opt_reg[sel_cs];
  assign act_extw  = lat_extw_reg[{act_cs_reg, 1'b0} +: 2];
  assign act_rdctl = lat_rdctl_reg[act_cs_reg];
  assign act_float = lat_float_reg[{act_cs_reg, 2'b00} +: 4];
  // A pending float blocks a write anywhere or a read on another device.
  assign fl_block  = fl_busy && (sel_write || (sel_cs != fl_cs));
  assign need_cs   = last_valid_reg && (req_cs_i != last_cs_reg);
  assign need_r2w  = last_valid_reg && !last_write_reg && req_write_i;
  assign slow_edge = (slow_mode_i != slow_prev_reg);

  // Internal memory accesses bypass the sequencer, so float periods never delay them.
  assign int_ack_o = int_req_i;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state logic.
  always @* begin
    state_next       = state_reg;
    cnt_next         = cnt_reg;
    after_setup_next = after_setup_reg;
    float_start      = 1'b0;
    finish           = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (accept) begin
          if (need_cs) begin
            state_next = ST_CSWAIT;
          end else if (reload_pend_reg || slow_edge) begin
            state_next = ST_RELOAD;
          end else if (need_r2w) begin
            state_next = ST_R2W;
          end else if (!sel_opt && fl_block) begin
            state_next       = ST_FLOAT;
            after_setup_next = 1'b0;
          end else if (req_setup_i != {`SMW_PH_W{1'b0}}) begin
            state_next = ST_SETUP;
            cnt_next   = req_setup_i;
          end else if (fl_block) begin
            state_next       = ST_FLOAT;
            after_setup_next = 1'b1;
          end else begin
            state_next = ST_PULSE;
            cnt_next   = req_pulse_i;
          end
        end
      end
      ST_CSWAIT, ST_RELOAD, ST_R2W: begin
        // The read-to-write cycle comes after a chip select or reload wait.
        if (state_reg != ST_R2W && r2w_due_reg) begin
          state_next = ST_R2W;
        end else if (!sel_opt && fl_block) begin
          state_next       = ST_FLOAT;
          after_setup_next = 1'b0;
        end else if (act_setup_reg != {`SMW_PH_W{1'b0}}) begin
          state_next = ST_SETUP;
          cnt_next   = act_setup_reg;
        end else if (fl_block) begin
          state_next       = ST_FLOAT;
          after_setup_next = 1'b1;
        end else begin
          state_next = ST_PULSE;
          cnt_next   = act_pulse_reg;
        end
      end
      ST_FLOAT: begin
        if (!fl_block) begin
          if (!after_setup_reg && act_setup_reg != {`SMW_PH_W{1'b0}}) begin
            state_next = ST_SETUP;
            cnt_next   = act_setup_reg;
          end else begin
            state_next = ST_PULSE;
            cnt_next   = act_pulse_reg;
          end
        end
      end
      ST_SETUP: begin
        if (cnt_reg == PH_ONE) begin
          // Setup cycles have already run down the float timer; wait only for the rest.
          if (fl_block) begin
            state_next       = ST_FLOAT;
            after_setup_next = 1'b1;
          end else begin
            state_next = ST_PULSE;
            cnt_next   = act_pulse_reg;
          end
        end else begin
          cnt_next = cnt_reg - PH_ONE;
        end
      end
      ST_PULSE: begin
        // The wait input matters here and in ST_SUSP only; no other state consults it.
        if (act_extw == `SMW_EXTW_FROZEN && !wait_s) begin
          state_next = ST_PULSE;
        end else if (cnt_reg != PH_ONE) begin
          cnt_next = cnt_reg - PH_ONE;
        end else if (act_extw == `SMW_EXTW_READY && !wait_s) begin
          state_next = ST_SUSP;
        end else if (act_hold_reg != {`SMW_PH_W{1'b0}}) begin
          state_next  = ST_HOLD;
          cnt_next    = act_hold_reg;
          float_start = !act_write_reg && act_rdctl;
        end else begin
          finish      = 1'b1;
          float_start = !act_write_reg;
        end
      end
      ST_SUSP: begin
        if (wait_s) begin
          if (act_hold_reg != {`SMW_PH_W{1'b0}}) begin
            state_next  = ST_HOLD;
            cnt_next    = act_hold_reg;
            float_start = !act_write_reg && act_rdctl;
          end else begin
            finish      = 1'b1;
            float_start = !act_write_reg;
          end
        end
      end
      ST_HOLD: begin
        if (cnt_reg == PH_ONE) begin
          finish      = 1'b1;
          float_start = !act_write_reg && !act_rdctl;
        end else begin
          cnt_next = cnt_reg - PH_ONE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (finish) begin
      state_next = ST_IDLE;
      cnt_next   = {`SMW_PH_W{1'b0}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State, counter and access registers.
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      state_reg       <= ST_IDLE;
      cnt_reg         <= {`SMW_PH_W{1'b0}};
      after_setup_reg <= 1'b0;
      act_write_reg   <= 1'b0;
      act_cs_reg      <= {`SMW_CS_W{1'b0}};
      act_setup_reg   <= {`SMW_PH_W{1'b0}};
      act_pulse_reg   <= PH_ONE;
      act_hold_reg    <= {`SMW_PH_W{1'b0}};
      r2w_due_reg     <= 1'b0;
    end else begin
      state_reg       <= state_next;
      cnt_reg         <= cnt_next;
      after_setup_reg <= after_setup_next;
      if (accept) begin
        act_write_reg <= req_write_i;
        act_cs_reg    <= req_cs_i;
        act_setup_reg <= req_setup_i;
        act_pulse_reg <= req_pulse_i;
        act_hold_reg  <= req_hold_i;
        r2w_due_reg   <= need_r2w;
      end
    end
  end

  // History of the last external access, used to pick chip select and read-to-write waits.
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      last_valid_reg <= 1'b0;
      last_write_reg <= 1'b0;
      last_cs_reg    <= {`SMW_CS_W{1'b0}};
    end else if (finish) begin
      last_valid_reg <= 1'b1;
      last_write_reg <= act_write_reg;
      last_cs_reg    <= act_cs_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reload scheduling and configuration latch. Pending starts set, so the first access
  // after reset loads the settings. A new request to reload wins over the clear.
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      reload_pend_reg <= 1'b1;
      slow_prev_reg   <= 1'b0;
      lat_float_reg   <= `SMW_RST_FLOAT;
      lat_opt_reg     <= `SMW_RST_OPT;
      lat_rdctl_reg   <= `SMW_RST_RDCTL;
      lat_extw_reg    <= `SMW_RST_EXTW;
    end else begin
      slow_prev_reg <= slow_mode_i;
      if (mode_write_i || slow_edge) begin
        reload_pend_reg <= 1'b1;
      end else if (state_next == ST_RELOAD || state_next == ST_CSWAIT) begin
        reload_pend_reg <= 1'b0;
      end
      // One cycle of reload (or the chip select wait that absorbs it) latches everything.
      if (state_reg == ST_RELOAD || state_reg == ST_CSWAIT) begin
        lat_float_reg <= cfg_float_cycles_i;
        lat_opt_reg   <= cfg_float_opt_i;
        lat_rdctl_reg <= cfg_read_ctrl_i;
        lat_extw_reg  <= cfg_ext_wait_sel_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registered control outputs, decoded from the next state so the pins never glitch.
  // A frozen pulse keeps the state, hence all strobes stay unchanged.
  genvar gi;
  generate
    for (gi = 0; gi < `SMW_NUM_CS; gi = gi + 1) begin : g_cs
      always @(posedge core_clk_i) begin
        if (rst_i) begin
          cs_n_reg[gi] <= 1'b1;
        end else begin
          // The select of a request being taken now drives its first setup cycle.
          cs_n_reg[gi] <= !((sel_cs == gi) &&
                            (state_next == ST_SETUP || state_next == ST_PULSE ||
                             state_next == ST_SUSP  || state_next == ST_HOLD));
        end
      end
    end
  endgenerate

  // Strobes and wait indications; cs, reload and read-to-write waits drive all lines high.
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      rd_n_reg   <= 1'b1;
      wr_n_reg   <= 1'b1;
      ws_reg     <= 4'h0;
      done_reg   <= 1'b0;
      frozen_reg <= 1'b0;
    end else begin
      rd_n_reg   <= !((state_next == ST_PULSE || state_next == ST_SUSP) && !sel_write);
      wr_n_reg   <= !((state_next == ST_PULSE || state_next == ST_SUSP) && sel_write);
      ws_reg[`SMW_WS_CS]     <= (state_next == ST_CSWAIT);
      ws_reg[`SMW_WS_RELOAD] <= (state_next == ST_RELOAD);
      ws_reg[`SMW_WS_R2W]    <= (state_next == ST_R2W);
      ws_reg[`SMW_WS_FLOAT]  <= (state_next == ST_FLOAT);
      done_reg   <= finish;
      frozen_reg <= (state_reg == ST_PULSE) && (act_extw == `SMW_EXTW_FROZEN) && !wait_s;
    end
  end

  assign req_ready_o      = idle && (req_cs_i < `SMW_NUM_CS);
  assign done_o           = done_reg;
  assign chip_select_n_o  = cs_n_reg;
  assign read_strobe_n_o  = rd_n_reg;
  assign write_strobe_n_o = wr_n_reg;
  assign wait_state_o     = ws_reg;
  assign float_busy_o     = fl_busy;
  assign frozen_o         = frozen_reg;

endmodule // smw_ctrl

// ---- bench/smw_ctrl_sva.sv ----
// Port checker for the wait-state sequencer.
`timescale 1ns/1ns
module smw_ctrl_sva (
  input logic       core_clk_i,
  input logic       rst_i,
  input logic       int_req_i,
  input logic       int_ack_o,
  input logic [2:0] req_cs_i,
  input logic       req_ready_o,
  input logic       done_o,
  input logic [5:0] chip_select_n_o,
  input logic       read_strobe_n_o,
  input logic       write_strobe_n_o,
  input logic [3:0] wait_state_o,
  input logic       frozen_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////
  // Single-cycle wait steps, written as two-step sequences.
  sequence s_rl;
    wait_state_o[1] ##1 !wait_state_o[1];
  endsequence
  sequence s_rw;
    wait_state_o[2] ##1 !wait_state_o[2];
  endsequence
  property p_reload_one; wait_state_o[1] |-> s_rl; endproperty
  property p_r2w_one; wait_state_o[2] |-> s_rw; endproperty
  property p_r2w_apart; wait_state_o[2] |-> !wait_state_o[1] && !wait_state_o[0]; endproperty
  property p_cs_idle;
    wait_state_o[0] |-> &chip_select_n_o && read_strobe_n_o && write_strobe_n_o
      && !wait_state_o[1];
  endproperty
  property p_float_quiet; wait_state_o[3] |-> read_strobe_n_o && write_strobe_n_o; endproperty
  property p_int_ack; int_ack_o == int_req_i; endproperty
  property p_frozen_hold;
    frozen_o |-> $stable(chip_select_n_o) && $stable(read_strobe_n_o)
      && $stable(write_strobe_n_o);
  endproperty
  property p_frozen_pulse; frozen_o |-> !(read_strobe_n_o && write_strobe_n_o); endproperty
  property p_done_pulse; done_o |=> !done_o; endproperty
  property p_refuse; req_cs_i > 3'h5 |-> !req_ready_o; endproperty
  a_reload_one: assert property (p_reload_one) else $error("reload wait too long");
  a_r2w_one: assert property (p_r2w_one) else $error("r2w wait too long");
  a_r2w_apart: assert property (p_r2w_apart) else $error("r2w merged");
  a_cs_idle: assert property (p_cs_idle) else $error("cs wait not idle");
  a_float_quiet: assert property (p_float_quiet) else $error("strobe in float");
  a_int_ack: assert property (p_int_ack) else $error("internal access held");
  a_frozen_hold: assert property (p_frozen_hold) else $error("output moved");
  a_frozen_pulse: assert property (p_frozen_pulse) else $error("freeze off pulse");
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");
  a_refuse: assert property (p_refuse) else $error("bad chip select taken");
endmodule // smw_ctrl_sva

// ---- bench/smw_ext_dev.sv ----
// Model of an external device that answers a strobe with a low wait pulse.
`timescale 1ns/1ns
module smw_ext_dev (
  input  wire       core_clk_i,
  input  wire       read_strobe_n_i,
  input  wire       write_strobe_n_i,
  input  wire [3:0] wait_len_i,
  output wire       ext_wait_n_o
);
  reg  [3:0] age_reg = 4'h0;
  wire       strobe_on = !read_strobe_n_i || !write_strobe_n_i;
  // Age of the current pulse; saturates so a long suspend never re-arms the wait.
  always @(posedge core_clk_i) begin
    age_reg <= !strobe_on ? 4'h0 : (age_reg == 4'hF ? age_reg : age_reg + 4'h1);
  end
  // Wait is low only inside a pulse, until the device is ready; pulled up elsewhere.
  assign ext_wait_n_o = !(strobe_on && age_reg < wait_len_i);
endmodule // smw_ext_dev

// ---- bench/smw_ctrl_tb.sv ----
// Self-checking testbench of the wait-state sequencer.
`timescale 1ns/1ns
module smw_ctrl_tb;
  logic        clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0;
  logic        int_req = 1'b0, mode_write = 1'b0, slow_mode = 1'b0;
  logic [2:0]  req_cs = 3'h0;
  logic [9:0]  req_setup = 10'h001, req_pulse = 10'h002, req_hold = 10'h001;
  logic [23:0] cfg_float = 24'h000000;
  logic [5:0]  cfg_opt = 6'h00, cfg_rdctl = 6'h00, cs_n;
  logic [11:0] cfg_extw = 12'h000;
  logic [3:0]  wait_len = 4'h0, ws;
  wire         ready, done, int_ack, rd_n, wr_n, fbusy, frozen, wait_n;
  int          miscompares = 0, tests_run = 0, len, n_ws[4], fb_cs, n_frz, n_strb;
  smw_ctrl i_dut (.core_clk_i(clk), .rst_i(rst), .req_valid_i(req_valid),
    .req_ready_o(ready), .req_write_i(req_write), .req_cs_i(req_cs),
    .req_setup_i(req_setup), .req_pulse_i(req_pulse), .req_hold_i(req_hold),
    .done_o(done), .int_req_i(int_req), .int_ack_o(int_ack), .mode_write_i(mode_write),
    .slow_mode_i(slow_mode), .cfg_float_cycles_i(cfg_float), .cfg_float_opt_i(cfg_opt),
    .cfg_read_ctrl_i(cfg_rdctl), .cfg_ext_wait_sel_i(cfg_extw), .ext_wait_n_i(wait_n),
    .chip_select_n_o(cs_n), .read_strobe_n_o(rd_n), .write_strobe_n_o(wr_n),
    .wait_state_o(ws), .float_busy_o(fbusy), .frozen_o(frozen));
  smw_ext_dev i_dev (.core_clk_i(clk), .read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n),
    .wait_len_i(wait_len), .ext_wait_n_o(wait_n));
  ////////////////////////////////////////////////////////////////
  // Free-running 25 MHz clock.
  initial begin
    forever #20 clk = ~clk;
  end
  // Compare and count; case inequality so an unknown never matches.
  task chk(input string what, input logic [31:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %0d got %0d", what, exp, got);
    end
  endtask
  // One access; records its length, wait cycles, float overlap and frozen cycles.
  task access(input logic wr, input logic [2:0] cs, input logic [9:0] s, p, h);
    int i;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_cs <= cs;
    req_setup <= s;
    req_pulse <= p;
    req_hold <= h;
    @(negedge clk);
    for (i = 0; i < 50 && ready !== 1'b1; i++) @(negedge clk);
    chk("ready", 1, ready);
    @(posedge clk);
    req_valid <= 1'b0;
    len = 0;
    n_ws = '{0, 0, 0, 0};
    fb_cs = 0;
    n_frz = 0;
    n_strb = 0;
    @(negedge clk);
    for (i = 0; i < 300 && done !== 1'b1; i++) begin
      len++;
      foreach (n_ws[k]) n_ws[k] += ws[k];
      fb_cs |= fbusy & ~&cs_n;
      n_frz += frozen;
      n_strb += !rd_n || !wr_n;
      @(negedge clk);
    end
    // Strobe cycles stand for the pulse plus any frozen or suspended cycles.
    chk("length", s + h + n_strb + n_ws[0] + n_ws[1] + n_ws[2] + n_ws[3], len);
    if (wait_len == 4'h0) chk("pulse", p, n_strb);
  endtask
  // Signals one mode configuration write.
  task mode_pulse;
    @(posedge clk);
    mode_write <= 1'b1;
    @(posedge clk);
    mode_write <= 1'b0;
  endtask
  task t_reload;
    access(0, 0, 1, 2, 1); chk("reload", 1, n_ws[1]);
    access(0, 0, 1, 2, 1); chk("reload", 0, n_ws[1]);
    mode_pulse;
    access(0, 0, 1, 2, 1); chk("reload", 1, n_ws[1]);
    slow_mode <= 1'b1;
    access(0, 0, 1, 2, 1); chk("reload", 1, n_ws[1]);
    slow_mode <= 1'b0;
    access(0, 0, 1, 2, 1); chk("reload", 1, n_ws[1]);
    $display("t_reload finished");
  endtask
  task t_r2w;
    access(1, 0, 1, 2, 1); chk("r2w", 1, n_ws[2]);
    chk("float", 0, n_ws[3]);
    access(0, 0, 1, 2, 1);
    access(1, 1, 1, 2, 1); chk("cs_r2w", 2, n_ws[0] + n_ws[2]);
    mode_pulse;
    access(1, 2, 1, 2, 1); chk("cs", 1, n_ws[0]);
    chk("reload", 0, n_ws[1]);
    $display("t_r2w finished");
  endtask
  task t_float;
    cfg_float <= 24'h00000F;
    cfg_rdctl <= 6'h01;
    mode_pulse;
    access(0, 0, 1, 2, 2); chk("float_hold", 1, fb_cs);
    @(posedge clk);
    int_req <= 1'b1;
    @(negedge clk); chk("int_ack", 1, int_ack & fbusy);
    @(posedge clk);
    int_req <= 1'b0;
    access(0, 0, 1, 2, 1); chk("float", 0, n_ws[3]);
    access(1, 0, 1, 2, 1); chk("float", 1, n_ws[3] != 0);
    cfg_rdctl <= 6'h00;
    mode_pulse;
    access(0, 0, 1, 2, 2); chk("float_hold", 0, fb_cs);
    cfg_opt <= 6'h01;
    cfg_float <= 24'h000006;
    mode_pulse;
    access(0, 0, 1, 2, 1);
    access(1, 0, 20, 2, 1); chk("float", 0, n_ws[3]);
    $display("t_float finished");
  endtask
  // Pulse 6 and hold 1 keep the host limits on wait use.
  task xw(input logic [2:0] cs, input logic [3:0] wl, input logic longer);
    wait_len <= wl;
    access(0, cs, 1, 6, 1);
    chk("stretch", longer, n_strb > 6);
  endtask
  task t_extwait;
    cfg_float <= 24'h000000;
    cfg_opt <= 6'h00;
    cfg_extw <= 12'h380;
    mode_pulse;
    xw(3, 4, 1); chk("frozen", 1, n_frz != 0);
    xw(4, 4, 1);
    xw(4, 2, 0);
    xw(5, 4, 0);
    $display("t_extwait finished");
  endtask
  // A request to a chip select that does not exist is never taken.
  task t_refuse;
    @(posedge clk);
    req_valid <= 1'b1;
    req_cs <= 3'h6;
    repeat (3) @(negedge clk);
    chk("refuse_ready", 0, ready);
    chk("refuse_cs", 1, &cs_n);
    @(posedge clk);
    req_valid <= 1'b0;
    req_cs <= 3'h0;
    $display("t_refuse finished");
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Main sequence after an 8-cycle reset.
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reload;
    t_r2w;
    t_float;
    t_extwait;
    t_refuse;
    stop_test;
  end
  // Watchdog well beyond the expected run of under 300 cycles.
  initial begin
    #400000;
    miscompares++;
    stop_test;
  end
endmodule // smw_ctrl_tb
bind smw_ctrl smw_ctrl_sva i_sva (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .int_req_i(int_req_i), .int_ack_o(int_ack_o), .req_cs_i(req_cs_i),
  .req_ready_o(req_ready_o), .done_o(done_o), .chip_select_n_o(chip_select_n_o),
  .read_strobe_n_o(read_strobe_n_o), .write_strobe_n_o(write_strobe_n_o),
  .wait_state_o(wait_state_o), .frozen_o(frozen_o));
